// ---- hdl/swt_defs.svh ----
// constants of the self wake-up timer: register indices, field positions,
// reset values and timing figures; included by the divider, prescaler, core and test files
`ifndef SWT_DEFS_SVH
`define SWT_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define SWT_IDX_RELOAD 10'h086
`define SWT_IDX_CONTROL 10'h08f
`define SWT_IDX_IRQ_EN 10'h090
`define SWT_IDX_IRQ_STATUS 10'h091
`define SWT_IDX_IRQ_MASK 10'h092

// control register fields
`define SWT_CTL_PS_LSB 0
`define SWT_CTL_PS_MSB 2
`define SWT_CTL_RUN_BIT 3
`define SWT_CTL_FLAG_BIT 4

// irq enable register fields
`define SWT_IEN_WAKE_BIT 0
`define SWT_IEN_GLOBAL_BIT 1

// irq status and mask fields
`define SWT_IST_OVF_BIT 0
`define SWT_IST_RELOAD_BUSY_BIT 1

`define SWT_RELOAD_RST 8'h00
`define SWT_CONTROL_RST 8'h00
`define SWT_CNT_TOP 8'hff

// prescale shift per select code, four bits each, code 0 lowest
`define SWT_PS_SHIFT_TABLE 32'hba98_6420

// timer clock period against system clock period
`define SWT_LS_PERIOD_NS 100000
`define SWT_REF_PERIOD_NS 100
`define SWT_LS_DIV (`SWT_LS_PERIOD_NS / `SWT_REF_PERIOD_NS)

`endif

// ---- hdl/swt_pkg.sv ----
// types of the self wake-up timer
// assumes swt_defs.svh is compiled alongside
`default_nettype none

package swt_pkg;

    typedef struct packed {
        logic [9:0] cnt;
    } swt_div_t;

    typedef struct packed {
        logic [10:0] cnt;
    } swt_ps_t;

    typedef struct packed {
        logic [7:0] reload;
        logic flag;
        logic run;
        logic [2:0] ps_sel;
        logic [7:0] cnt;
        logic ps_clear;
        logic wake_ien;
        logic glob_ien;
        logic [1:0] ists;
        logic [1:0] imask;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic wake;
        logic osc_hold;
    } swt_core_t;

endpackage

`default_nettype wire

// ---- hdl/swt_tick_if.sv ----
// tick path between the timer core, the timer clock divider and the prescaler
// assumes all three run on ref_clk
`timescale 1ns/1ps
`default_nettype none

interface swt_tick_if;
    logic ls_tick;
    logic clear;
    logic [2:0] sel;
    logic tick_out;

    modport div (output ls_tick);
    modport presc (input ls_tick, input clear, input sel, output tick_out);
    modport core (output clear, output sel, input tick_out);
endinterface

`default_nettype wire

// ---- hdl/swt_ls_div.sv ----
// timer clock source: a free-running divider that makes a one-cycle
// enable at the 10 kHz timer rate from ref_clk
// assumes ref_clk at 10 MHz
`timescale 1ns/1ps
`default_nettype none
`include "swt_defs.svh"

module swt_ls_div #(
    parameter int LS_DIV = `SWT_LS_DIV
) (
    input wire logic ref_clk,
    input wire logic resetn,
    swt_tick_if.div tk
);
    localparam logic [9:0] DIV_LAST = 10'(LS_DIV - 1);

    swt_pkg::swt_div_t st_r;
    swt_pkg::swt_div_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt == DIV_LAST) begin
            st_nxt.cnt = 10'h000;
        end else begin
            st_nxt.cnt = st_r.cnt + 10'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // never stopped: the oscillator stays live through idle and power-down
    assign tk.ls_tick = (st_r.cnt == DIV_LAST);
endmodule

`default_nettype wire

// ---- hdl/swt_prescaler.sv ----
// prescaler of the wake timer: passes one timer tick in 1, 4, 16 ... 2048
// assumes ls_tick is a one-cycle enable on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "swt_defs.svh"

module swt_prescaler (
    input wire logic ref_clk,
    input wire logic resetn,
    swt_tick_if.presc tk
);
    localparam logic [31:0] SHIFT_TABLE = `SWT_PS_SHIFT_TABLE;

    swt_pkg::swt_ps_t st_r;
    swt_pkg::swt_ps_t st_nxt;
    logic [3:0] shift;
    logic [10:0] term;

    assign shift = SHIFT_TABLE[{tk.sel, 2'b00} +: 4];
    assign term = 11'((12'h001 << shift) - 12'h001);

    always_comb begin
        st_nxt = st_r;
        if (tk.clear) begin
            st_nxt.cnt = 11'h000;
        end else if (tk.ls_tick) begin
            if (st_r.cnt >= term) begin
                st_nxt.cnt = 11'h000;
            end else begin
                st_nxt.cnt = st_r.cnt + 11'h001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tk.tick_out = tk.ls_tick && !tk.clear && (st_r.cnt >= term);
endmodule

`default_nettype wire

// ---- hdl/swt_core.sv ----
// self wake-up timer: 8-bit auto-reload up counter on a prescaled 10 kHz
// tick, with its registers on a classic wishbone slave
// assumes ref_clk 10 MHz; cpu power state does not gate this block
`timescale 1ns/1ps
`default_nettype none
`include "swt_defs.svh"

// Operation
// - eight-bit auto-reload up counter fed through a three-bit selectable prescaler
// - prescale codes 000..111 divide by 1,4,16,64,256,512,1024,2048
// - run bit one starts counting, zero halts it
// - rollover from FFH sets overflow flag and reloads the reload byte
// - interrupt while flag set and both wake and global enables set
// - hardware never clears the flag; software clears it writing zero
// - counting continues in idle and power-down
// - only clock is the internal 10 kHz source, kept active while running
// - overflow serves as periodic wake-up and as general timer event
module swt_core #(
    parameter int LS_DIV = `SWT_LS_DIV
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic wake_o,
    output logic osc_hold_o
);
    swt_tick_if tk();

    swt_pkg::swt_core_t st_r;
    swt_pkg::swt_core_t st_nxt;

    logic req;
    logic wr;
    logic [9:0] idx;
    logic [7:0] wbyte;
    logic [7:0] ctl_rd;
    logic ovf;

    swt_ls_div #(
        .LS_DIV(LS_DIV)
    ) swt_ls_div_inst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tk(tk)
    );

    swt_prescaler swt_prescaler_inst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tk(tk)
    );

    assign tk.clear = st_r.ps_clear;
    assign tk.sel = st_r.ps_sel;

    // a new request is taken only when no ack is out, giving one idle gap
    assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[11:2];
    assign wbyte = wb_dat_i[7:0];
    assign ovf = st_r.run && !st_r.ps_clear && tk.tick_out && (st_r.cnt == `SWT_CNT_TOP);

    always_comb begin
        ctl_rd = 8'h00;
        ctl_rd[`SWT_CTL_PS_MSB:`SWT_CTL_PS_LSB] = st_r.ps_sel;
        ctl_rd[`SWT_CTL_RUN_BIT] = st_r.run;
        ctl_rd[`SWT_CTL_FLAG_BIT] = st_r.flag;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req;
        st_nxt.ps_clear = 1'b0;
        st_nxt.wake = 1'b0;

        // counting only while run is set
        if (st_r.run && !st_r.ps_clear && tk.tick_out) begin
            if (ovf) begin
                st_nxt.cnt = st_r.reload;
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end

        // register writes
        if (wr) begin
            unique case (idx)
                `SWT_IDX_RELOAD: begin
                    st_nxt.reload = wbyte;
                    // a write while running is flagged in the status, and the new value is still stored
                    if (st_r.run) begin
                        st_nxt.ists[`SWT_IST_RELOAD_BUSY_BIT] = 1'b1;
                    end
                end
                `SWT_IDX_CONTROL: begin
                    st_nxt.ps_sel = wbyte[`SWT_CTL_PS_MSB:`SWT_CTL_PS_LSB];
                    st_nxt.run = wbyte[`SWT_CTL_RUN_BIT];
                    // zero clears, a one leaves the flag alone
                    if (!wbyte[`SWT_CTL_FLAG_BIT]) begin
                        st_nxt.flag = 1'b0;
                    end
                    // fresh start reloads the count and clears the prescaler, not the divider
                    if (wbyte[`SWT_CTL_RUN_BIT] && !st_r.run) begin
                        st_nxt.cnt = st_r.reload;
                        st_nxt.ps_clear = 1'b1;
                    end
                end
                `SWT_IDX_IRQ_EN: begin
                    st_nxt.wake_ien = wbyte[`SWT_IEN_WAKE_BIT];
                    st_nxt.glob_ien = wbyte[`SWT_IEN_GLOBAL_BIT];
                end
                `SWT_IDX_IRQ_STATUS: begin
                    st_nxt.ists = st_nxt.ists & ~wbyte[1:0];
                end
                `SWT_IDX_IRQ_MASK: begin
                    st_nxt.imask = wbyte[1:0];
                end
                default: begin
                end
            endcase
        end

        // hardware sets come after the clears so a coincident event wins
        if (ovf) begin
            // flag lives on ref_clk already, no crossing needed
            st_nxt.flag = 1'b1;
            st_nxt.ists[`SWT_IST_OVF_BIT] = 1'b1;
            st_nxt.wake = 1'b1;
        end
        if (wr && idx == `SWT_IDX_RELOAD && st_r.run) begin
            st_nxt.ists[`SWT_IST_RELOAD_BUSY_BIT] = 1'b1;
        end

        // register reads
        st_nxt.dat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (idx)
                `SWT_IDX_RELOAD: st_nxt.dat[7:0] = st_r.reload;
                `SWT_IDX_CONTROL: st_nxt.dat[7:0] = ctl_rd;
                `SWT_IDX_IRQ_EN: begin
                    st_nxt.dat[`SWT_IEN_WAKE_BIT] = st_r.wake_ien;
                    st_nxt.dat[`SWT_IEN_GLOBAL_BIT] = st_r.glob_ien;
                end
                `SWT_IDX_IRQ_STATUS: st_nxt.dat[1:0] = st_r.ists;
                `SWT_IDX_IRQ_MASK: st_nxt.dat[1:0] = st_r.imask;
                default: st_nxt.dat = 32'h0000_0000;
            endcase
        end

        // level request from flag and both enables, or masked status
        st_nxt.irq = (st_nxt.flag && st_nxt.wake_ien && st_nxt.glob_ien)
            || |(st_nxt.ists & st_nxt.imask);
        // keep the timer clock alive through low power while running
        // nothing here looks at the cpu power state
        st_nxt.osc_hold = st_nxt.run;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.reload <= `SWT_RELOAD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign irq_o = st_r.irq;
    assign wake_o = st_r.wake;
    assign osc_hold_o = st_r.osc_hold;
endmodule

`default_nettype wire

// ---- tb/swt_core_asserts.sv ----
// port checker of the wake timer top
// assumes one ref_clk domain and a short timer tick
`timescale 1ns/1ps
`default_nettype none
`include "swt_defs.svh"
module swt_core_asserts #(
    parameter int LS_DIV = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic osc_hold_o
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [15:0] gap_r;
    // saturate so a long idle spell cannot wrap into a short gap
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            gap_r <= 16'hffff;
        else if (wake_o)
            gap_r <= 16'h0001;
        else if (gap_r != 16'hffff)
            gap_r <= gap_r + 16'h0001;
    end
    sequence req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ctl_wr;
        req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == `SWT_IDX_CONTROL;
    endsequence
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (req |=> wb_ack_o)
        else $error("request not answered");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_run_hold:
        assert property (ctl_wr |=> ##1 osc_hold_o == $past(wb_dat_i[3], 2))
        else $error("hold level differs from run bit");
    chk_wake_gap: assert property (wake_o |-> gap_r >= LS_DIV)
        else $error("overflows closer than one tick");
    chk_wake_run:
        assert property (wake_o |-> osc_hold_o || $past(osc_hold_o) || $past(osc_hold_o, 2))
        else $error("overflow while halted");
    chk_irq_rise: assert property ($rose(irq_o) |-> wb_ack_o || wake_o || $past(wake_o))
        else $error("irq rose without cause");
    chk_irq_fall:
        assert property ($fell(irq_o) |-> wb_ack_o && wb_we_i || $past(wb_ack_o && wb_we_i))
        else $error("irq fell without a write");
endmodule
bind swt_core swt_core_asserts #(.LS_DIV(LS_DIV)) swt_core_asserts_inst (.ref_clk, .resetn,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .irq_o, .wake_o, .osc_hold_o);
`default_nettype wire

// ---- tb/tb_swt_core.sv ----
// self-checking bench of the wake timer: registers, periods, interrupts
// assumes swt_core as top with a four-cycle timer tick
`timescale 1ns/1ps
`default_nettype none
`include "swt_defs.svh"
module tb_swt_core;
    // timer tick of four system clocks, at least two
    localparam int LSD = 4;
    localparam logic [9:0] RL = `SWT_IDX_RELOAD;
    localparam logic [9:0] CT = `SWT_IDX_CONTROL;
    localparam logic [9:0] EN = `SWT_IDX_IRQ_EN;
    localparam logic [9:0] ST = `SWT_IDX_IRQ_STATUS;
    localparam logic [9:0] MK = `SWT_IDX_IRQ_MASK;
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic req = 1'h0;
    logic we = 1'h0;
    logic [11:0] adr = 12'h000;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr;
    logic [31:0] rd;
    logic ack;
    logic irq;
    logic wake;
    logic hold;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int ratio[8] = '{1, 4, 16, 64, 256, 512, 1024, 2048};
    swt_core #(.LS_DIV(LSD)) swt_core_inst (.ref_clk(ref_clk), .resetn(resetn),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .irq_o(irq), .wake_o(wake),
        .osc_hold_o(hold));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_total++;
            results();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until ack is sampled, released on that same edge
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        req <= 1'h1;
        we <= w;
        adr <= {idx, 2'h0};
        dw <= {24'h0, d};
        do @(posedge ref_clk); while (ack !== 1'h1);
        rd = dr;
        req <= 1'h0;
    endtask
    task automatic wait_wake();
        do @(posedge ref_clk); while (wake !== 1'h1);
    endtask
    task automatic t_regs();
        bus(1'h0, RL, 8'h00);
        check("reload", rd, 32'h0);
        bus(1'h0, CT, 8'h00);
        check("control", rd, 32'h0);
        bus(1'h1, RL, 8'ha5);
        bus(1'h0, RL, 8'h00);
        check("reload", rd, 32'h0000_00a5);
        bus(1'h1, CT, 8'hf7);
        bus(1'h0, CT, 8'h00);
        check("control", rd, 32'h0000_0007);
        bus(1'h1, 10'h3ff, 8'hff);
        bus(1'h0, 10'h3ff, 8'h00);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic t_period(input logic [2:0] ps, input int n);
        int t;
        int t0;
        bus(1'h1, CT, 8'h00);
        // reload changed only while halted, and never ff
        bus(1'h1, RL, 8'hfe);
        bus(1'h1, CT, {5'h01, ps});
        t0 = cycles;
        // started just before low power, timer clock held on
        check("hold", hold, 1'h1);
        wait_wake();
        t = cycles;
        // first period full, less at most one free-running tick phase
        check("first", (t - t0 > 2 * n * LSD - LSD) && (t - t0 <= 2 * n * LSD + 1), 1'h1);
        wait_wake();
        check("period", cycles - t, 2 * n * LSD);
        bus(1'h0, CT, 8'h00);
        check("flag", rd, {24'h0, 5'h03, ps});
    endtask
    task automatic t_irq();
        bus(1'h1, EN, 8'h01);
        bus(1'h1, CT, 8'h00);
        check("hold", hold, 1'h0);
        bus(1'h1, RL, 8'hf0);
        bus(1'h1, CT, 8'h08);
        wait_wake();
        repeat (2) @(posedge ref_clk);
        check("irq", irq, 1'h0);
        bus(1'h1, EN, 8'h03);
        @(posedge ref_clk);
        check("irq", irq, 1'h1);
        bus(1'h1, CT, 8'h00);
        repeat (2) @(posedge ref_clk);
        check("irq", irq, 1'h0);
        bus(1'h1, MK, 8'h01);
        @(posedge ref_clk);
        check("irq", irq, 1'h1);
        bus(1'h1, ST, 8'h01);
        bus(1'h0, ST, 8'h00);
        check("status", rd, 32'h0);
        check("irq", irq, 1'h0);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'h1;
        // let the timer clock settle before relying on it
        repeat (2 * LSD) @(posedge ref_clk);
        t_regs();
        for (int i = 0; i < 8; i++) begin
            t_period(i[2:0], ratio[i]);
        end
        t_irq();
        results();
    end
endmodule
`default_nettype wire
